// ### hdl/host_port_pkg.sv
package host_port_pkg;
  // Mode select pin codes
  localparam logic [2:0] MODE_CLOCKED = 3'h0;
  localparam logic [2:0] MODE_EXT_CLOCKED = 3'h1;
  localparam logic [2:0] MODE_NON_CLOCKED = 3'h2;
  localparam logic [2:0] MODE_TWO_WIRE = 3'h3;
  localparam int MODE_TEST_BIT = 2;
  localparam int ADDR_HI_W = 7;
  localparam int ADDR_LO_W = 8;
  localparam int DATA_W = 8;
  localparam int SRC_W = 8;
  // Primary clock and serial MII rate, for reference by the bench
  localparam int CLK_PERIOD_NS = 8;
  localparam int SERIAL_MHZ = 10;
  localparam logic [SRC_W-1:0] MASK_RESET = 8'h00;
  localparam logic [SRC_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  // Sync chain: three flops, change taken when last two agree
  localparam int SYNC_LEN = 3;
  typedef enum logic [1:0] {
    BUS_CLOCKED,
    BUS_EXT_CLOCKED,
    BUS_NON_CLOCKED,
    BUS_TWO_WIRE
  } bus_kind_t;
endpackage : host_port_pkg

// ### hdl/host_port_and_strap_control.sv
`timescale 1ns/1ps
// What this block does
// RL1 - Upper pins: address high or two-wire address
// RL2 - Interrupt output low on pending events
// RL3 - Status write clears pending, deasserts interrupt
// RL4 - Mask register gates each interrupt source
// RL5 - Host drives active-low select and strobes
// RL6 - High reset restores every register default
// RL7 - Straps resampled anew after each reset
// RL8 - Primary clock runs all internal logic
// RL9 - External clocked mode times bus by aux
// RL10 - Aux host clock may exceed 25MHz
// RL11 - Link high means line disconnected
// RL12 - Serial strap low selects 10MHz serial MII
// RL13 - Floating serial strap gives nibble MII
// RL14 - Duplex strap: 0 full, 1 half
// RL15 - Mode pins choose host interface type
// RL16 - Data driven only when select and read low
// RL17 - Asynchronous straps and link synchronised first
module host_port_and_strap_control
  import host_port_pkg::*;
(
  input wire logic clk, // Primary clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic [ADDR_HI_W-1:0] addrHigh, // Upper address pins
  input wire logic [ADDR_LO_W-1:0] addrLow, // Lower address pins
  input wire logic [DATA_W-1:0] dataIn, // Data bus input
  output logic [DATA_W-1:0] dataOut, // Data bus output
  output logic dataOe, // Data bus drive enable
  input wire logic chipSelect_n, // Chip select
  input wire logic writeStrobe_n, // Write strobe
  input wire logic readStrobe_n, // Read strobe
  input wire logic auxHostClock, // Aux host clock pin
  input wire logic [2:0] modeSelect, // Mode select pins
  input wire logic link_n, // PHY link status
  input wire logic serialSelect_n, // Serial strap
  input wire logic duplexSelect_n, // Duplex strap
  input wire logic [SRC_W-1:0] srcEvent, // Rx/tx event pulses
  input wire logic statusWrite, // Status register write
  input wire logic [SRC_W-1:0] statusClear, // Bits to clear
  input wire logic maskWrite, // Mask register write
  input wire logic [SRC_W-1:0] maskData, // New mask, 1 enables
  input wire logic [DATA_W-1:0] readData, // Core read data
  output logic interrupt_n, // Interrupt, active low
  output logic [SRC_W-1:0] interruptStatus, // Pending sources
  output logic [SRC_W-1:0] interruptMask, // Mask register
  output logic [ADDR_HI_W+ADDR_LO_W-1:0] busAddr, // Full address
  output logic [ADDR_HI_W-1:0] twoWireDeviceAddress, // Device addr
  output logic busWrite, // Write pulse toward core
  output logic busRead, // Read pulse toward core
  output logic [DATA_W-1:0] writeData, // Captured write data
  output bus_kind_t busKind, // Host interface type
  output logic testMode, // Factory test mode
  output logic lineDown, // Line disconnected
  output logic serialMii, // Serial MII at 10 MHz
  output logic halfDuplex // Half duplex
);

  ////////////////////////////////////////////////////////////////////////
  // Three-flop synchronisers; first stage feeds only the second [RL17]
  // Reset is taken as a level on rst_b; the RESET pin inversion is
  // done outside so the whole block shares one reset [RL6] [RL8]
  localparam int NSYNC = 9;
  // Bit positions inside the synchroniser word
  localparam int SY_AUX = 8;
  localparam int SY_CS = 7;
  localparam int SY_WR = 6;
  localparam int SY_RD = 5;
  localparam int SY_MODE_HI = 4;
  localparam int SY_MODE_LO = 2;
  localparam int SY_SERIAL = 1;
  localparam int SY_DUPLEX = 0;
  logic [NSYNC-1:0] syncIn;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] syncC;
  logic [NSYNC-1:0] stable;
  logic [NSYNC-1:0] agreed;

  assign syncIn = {auxHostClock, chipSelect_n, writeStrobe_n,
    readStrobe_n, modeSelect, serialSelect_n, duplexSelect_n};

  always_ff @(posedge clk)
  begin
    syncA <= syncIn; // [RL17]
    syncB <= syncA;
    syncC <= syncB;
  end

  assign agreed = ~(syncB ^ syncC);

  // Not reset: straps must flow through while reset is held, or the
  // capture below would only ever see a fixed pattern [RL7]
  always_ff @(posedge clk)
  begin
    stable <= (agreed & syncB) | (~agreed & stable); // [RL17]
  end

  logic auxSync;
  logic csSync_n;
  logic wrSync_n;
  logic rdSync_n;
  logic [2:0] modeSync;
  logic serialSync_n;
  logic duplexSync_n;
  assign auxSync = stable[SY_AUX];
  assign csSync_n = stable[SY_CS];
  assign wrSync_n = stable[SY_WR];
  assign rdSync_n = stable[SY_RD];
  assign modeSync = stable[SY_MODE_HI:SY_MODE_LO];
  assign serialSync_n = stable[SY_SERIAL];
  assign duplexSync_n = stable[SY_DUPLEX];

  logic linkA;
  logic linkB;
  logic linkC;
  always_ff @(posedge clk)
  begin
    linkA <= link_n; // [RL17]
    linkB <= linkA;
    linkC <= linkB;
  end

  ////////////////////////////////////////////////////////////////////////
  // Straps: captured while reset is held, frozen afterwards [RL7]
  logic [2:0] modeStrap;
  logic serialStrap_n;
  logic duplexStrap_n;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      modeStrap <= modeSync; // [RL7]
      serialStrap_n <= serialSync_n;
      duplexStrap_n <= duplexSync_n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busKind <= BUS_CLOCKED;
      testMode <= 1'b0;
      serialMii <= 1'b0;
      halfDuplex <= 1'b1;
    end
    else
    begin
      testMode <= modeStrap[MODE_TEST_BIT]; // [RL15]
      unique case (modeStrap[1:0])
        MODE_CLOCKED[1:0]: busKind <= BUS_CLOCKED;
        MODE_EXT_CLOCKED[1:0]: busKind <= BUS_EXT_CLOCKED; // [RL15]
        MODE_NON_CLOCKED[1:0]: busKind <= BUS_NON_CLOCKED;
        MODE_TWO_WIRE[1:0]: busKind <= BUS_TWO_WIRE;
      endcase
      // Pull-up keeps an open strap high: nibble mode [RL12] [RL13]
      serialMii <= ~serialStrap_n;
      halfDuplex <= duplexStrap_n; // [RL14]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      lineDown <= 1'b1;
    else if (linkB == linkC)
      lineDown <= linkB; // [RL11]
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus strobes; in external clocked mode a write or read is taken
  // on the aux clock's rising edge, so access time follows its rate.
  // Aux faster than clk/4 cannot be seen; the limit of this scheme.
  logic auxPrev;
  logic auxRise;
  logic wrActive;
  logic wrTake;
  logic rdTake;
  logic rdActive;
  logic wrPrev;
  logic rdPrev;
  logic parallelMode;
  logic sample;

  assign parallelMode = (busKind != BUS_TWO_WIRE) && !testMode;
  // One access per strobe fall; the gate carries mode and aux timing
  function automatic logic take_edge(input logic active, input logic prev,
    input logic gate);
    return gate && active && !prev;
  endfunction : take_edge

  assign auxRise = auxSync && !auxPrev;
  assign sample = (busKind == BUS_EXT_CLOCKED) ? auxRise : 1'b1; // [RL9]
  assign wrActive = !csSync_n && !wrSync_n; // [RL5]
  assign rdActive = !csSync_n && !rdSync_n;
  assign wrTake = take_edge(wrActive, wrPrev, parallelMode && sample);
  assign rdTake = take_edge(rdActive, rdPrev, parallelMode && sample);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      auxPrev <= 1'b0;
      wrPrev <= 1'b0;
      rdPrev <= 1'b0;
    end
    else
    begin
      auxPrev <= auxSync;
      if (sample)
      begin
        wrPrev <= wrActive;
        rdPrev <= rdActive;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busWrite <= 1'b0;
      busRead <= 1'b0;
      writeData <= DATA_RESET;
      busAddr <= '0;
    end
    else
    begin
      busWrite <= wrTake;
      busRead <= rdTake;
      if (wrTake)
        writeData <= dataIn;
      // Address follows the pins while selected, so it stands with
      // the strobe pulse that the core sees
      if (parallelMode && !csSync_n)
        busAddr <= {addrHigh, addrLow}; // [RL1]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      twoWireDeviceAddress <= '0;
    else if (busKind == BUS_TWO_WIRE)
      twoWireDeviceAddress <= addrHigh; // [RL1]
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data drive only during a select-and-read cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      dataOut <= DATA_RESET;
    else if (rdActive)
      dataOut <= readData;
  end

  assign dataOe = parallelMode && !chipSelect_n && !readStrobe_n; // [RL16]

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: set beats clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      interruptMask <= MASK_RESET; // [RL6]
    else if (maskWrite)
      interruptMask <= maskData; // [RL4]
  end

  logic [SRC_W-1:0] next_interruptStatus;

  always_comb
  begin
    next_interruptStatus = interruptStatus;
    if (statusWrite)
      next_interruptStatus = interruptStatus & ~statusClear; // [RL3]
    // Events OR-ed in last so a set beats a same-cycle clear
    next_interruptStatus = next_interruptStatus | srcEvent; // [RL2]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      interruptStatus <= STATUS_RESET; // [RL6]
    else
      interruptStatus <= next_interruptStatus;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      interrupt_n <= 1'b1;
    else
      interrupt_n <= ~|(interruptStatus & interruptMask); // [RL2] [RL4]
  end

endmodule : host_port_and_strap_control

// ### dv/host_port_monitor.sv
`timescale 1ns/1ps
module host_port_monitor
  import host_port_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic chipSelect_n, // Pin
  input wire logic readStrobe_n, // Pin
  input wire logic dataOe, // Out
  input wire logic [SRC_W-1:0] srcEvent, // In
  input wire logic statusWrite, // In
  input wire logic [SRC_W-1:0] statusClear, // In
  input wire logic maskWrite, // In
  input wire logic [SRC_W-1:0] maskData, // In
  input wire logic interrupt_n, // Out
  input wire logic [SRC_W-1:0] interruptStatus, // Out
  input wire logic [SRC_W-1:0] interruptMask // Out
);
  logic pend;
  assign pend = |(interruptStatus & interruptMask);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_oe_gate: assert property (
    dataOe |-> !chipSelect_n && !readStrobe_n) else $error("oe");
  a_irq_level: assert property (
    interrupt_n == !$past(pend)) else $error("irq");
  a_mask_gate: assert property (
    !pend |=> interrupt_n) else $error("masked");
  a_event_set: assert property (
    |srcEvent |=> &(interruptStatus | ~$past(srcEvent))) else $error("set");
  a_status_clear: assert property (
    statusWrite && !srcEvent |=> !(interruptStatus & $past(statusClear)))
    else $error("clear");
  a_clear_irq: assert property (
    statusWrite && statusClear == 8'hFF && !srcEvent |-> ##2 interrupt_n)
    else $error("release");
  a_mask_load: assert property (
    maskWrite |=> interruptMask == $past(maskData)) else $error("mask");
  a_reset_val: assert property (disable iff (1'b0)
    !rst_b |=> interrupt_n && interruptMask == MASK_RESET && !interruptStatus)
    else $error("reset");
  cover property (!interrupt_n);
  cover property (dataOe);
  cover property (statusWrite && !interrupt_n);
endmodule : host_port_monitor
////////////////////////////////////////
bind host_port_and_strap_control host_port_monitor host_port_monitor_i (.*);

// ### dv/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // Clock
  input wire logic go, // Start access
  input wire logic rd, // 1 reads
  output logic chipSelect_n, // Select
  output logic writeStrobe_n, // Write
  output logic readStrobe_n // Read
);
  logic [3:0] cnt = 4'h0;
  logic act;
  assign act = go || cnt > 4'h1;
  initial {chipSelect_n, writeStrobe_n, readStrobe_n} = 3'h7;
  // Low 8 edges, then high: beats the 4-cycle sync hold
  always @(posedge clk)
  begin
    cnt <= (go && cnt == 4'h0) ? 4'h8 : cnt - 4'(cnt != 4'h0);
    chipSelect_n <= !act;
    writeStrobe_n <= !(act && !rd);
    readStrobe_n <= !(act && rd);
  end
endmodule : host_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import host_port_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, rd = 1'b0;
  logic auxHostClock = 1'b0, link_n = 1'b1, statusWrite = 1'b0;
  logic maskWrite = 1'b0, serialSelect_n = 1'b1, duplexSelect_n = 1'b1;
  logic [6:0] addrHigh = 7'h00, twoWireDeviceAddress;
  logic [7:0] addrLow = 8'h00, dataIn = 8'h00, srcEvent = 8'h00;
  logic [7:0] statusClear = 8'h00, maskData = 8'h00, readData = 8'h00;
  logic [7:0] dataOut, interruptStatus, interruptMask, writeData;
  logic [14:0] busAddr;
  logic [2:0] modeSelect = 3'h0;
  logic [23:0] expQ[$], eq, e;
  logic dataOe, interrupt_n, busWrite, busRead, testMode, lineDown;
  logic serialMii, halfDuplex, chipSelect_n, writeStrobe_n, readStrobe_n;
  bus_kind_t busKind;
  int n_tests = 0, bad_count = 0;
  host_port_and_strap_control host_port_and_strap_control_i (.*);
  host_model host_model_i (.*);
  always #4 clk = !clk;
  // Aux at 31.25 MHz: above 25 MHz, slow enough to synchronise
  logic auxDiv = 1'b0;
  always @(posedge clk)
  begin
    auxDiv <= !auxDiv;
    if (auxDiv)
      auxHostClock <= !auxHostClock;
  end
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
    if (busWrite || busRead)
    begin
      eq = expQ.size() ? expQ.pop_front() : 24'hFFFFFF;
      e = {busRead, busAddr, busRead ? dataOut : writeData};
      chk("bus", e, eq);
    end
  task automatic acc(logic r, logic p);
    logic [22:0] v;
    v = 23'($urandom);
    {addrHigh, addrLow, dataIn} <= v;
    readData <= v[7:0];
    rd <= r;
    go <= 1'b1;
    if (p)
      expQ.push_back({r, v});
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    chk("oe", dataOe, p && r);
    if (p && r)
      chk("rdata", dataOut, v[7:0]);
    repeat (11) @(posedge clk);
  endtask : acc
  task automatic irq;
    logic [7:0] mk;
    mk = 8'($urandom) | 8'h01;
    maskData <= mk;
    maskWrite <= 1'b1;
    srcEvent <= ~mk;
    @(posedge clk);
    maskWrite <= 1'b0;
    srcEvent <= 8'h01;
    @(posedge clk);
    srcEvent <= 8'h00;
    repeat (3) @(posedge clk);
    chk("raised", {interrupt_n, interruptStatus}, {1'b0, ~mk | 8'h01});
    statusWrite <= 1'b1;
    statusClear <= 8'hFF;
    @(posedge clk);
    statusWrite <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cleared", {interrupt_n, interruptStatus}, 9'h100);
  endtask : irq
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hBD447F61));
    for (int m = 0; m < 5; m++)
    begin
      rst_b <= 1'b0;
      modeSelect <= 3'(m);
      {serialSelect_n, duplexSelect_n, link_n} <= 3'($urandom);
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      e = {m[2], !serialSelect_n, duplexSelect_n, link_n};
      // Flipped straps must not matter until the next reset
      {serialSelect_n, duplexSelect_n} <= ~{serialSelect_n, duplexSelect_n};
      repeat (6) @(posedge clk);
      chk("strap", {testMode, serialMii, halfDuplex, lineDown}, e);
      if (m < 4)
        chk("kind", busKind, 24'(m));
      acc(1'b0, m < 3);
      acc(1'b1, m < 3);
      if (m == 3)
        chk("dev", twoWireDeviceAddress, addrHigh);
      irq();
      $display("mode %0d done", m);
    end
    chk("left", 24'(expQ.size()), 24'h000000);
    tally_and_finish();
  end
endmodule : tb_top
